// File: verilog/pfs_pkg.sv
package pfs_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] PFS_ADDR_MASK   = 8'h00; // mux write-mask register
  localparam logic [7:0] PFS_ADDR_SELECT = 8'h04; // pin_function_select_2
  localparam logic [7:0] PFS_ADDR_GROUP  = 8'h08; // module group selects
  localparam logic [7:0] PFS_ADDR_STATUS = 8'h0C; // unlock / lost-write status

  localparam logic [31:0] PFS_SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] PFS_GROUP_RESET  = 32'h0000_0000;

  // ****************************************
  // field positions in pin_function_select_2
  // ****************************************
  localparam int PFS_F_A7_LSB  = 0;
  localparam int PFS_F_A8_LSB  = 2;
  localparam int PFS_F_A14_LSB = 14;
  localparam int PFS_F_A15_LSB = 16;
  localparam int PFS_F_A16_LSB = 18;
  localparam int PFS_F_A17_LSB = 21;
  localparam int PFS_F_A18_LSB = 24;
  localparam int PFS_F_A19_LSB = 27;
  localparam int PFS_F_A20_LSB = 30;
  localparam int PFS_N_2BIT_A8 = 6;

  // ****************************************
  // group-select register layout (own map)
  // ****************************************
  localparam int PFS_G_CS2    = 0;
  localparam int PFS_G_ADC    = 1;
  localparam int PFS_G_SA0    = 2;  // 2 bits
  localparam int PFS_G_SA4    = 4;  // 2 bits
  localparam int PFS_G_SA5    = 6;  // 2 bits
  localparam int PFS_G_FS0    = 8;
  localparam int PFS_G_CAN0   = 9;  // 2 bits
  localparam int PFS_G_CAN1   = 11; // 2 bits
  localparam int PFS_G_TMU    = 13;
  localparam int PFS_G_WIDTH  = 14;

  // ****************************************
  // codes
  // ****************************************
  localparam logic [31:0] PFS_UNLOCK_KEY = 32'hFFFF_FFFF; // mask = ~data written next
  localparam logic [1:0]  PFS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  PFS_GRP_ALT1      = 2'h1;
  localparam logic [2:0]  PFS_C0 = 3'h0;
  localparam logic [2:0]  PFS_C1 = 3'h1;
  localparam logic [2:0]  PFS_C2 = 3'h2;
  localparam logic [2:0]  PFS_C3 = 3'h3;
  localparam logic [2:0]  PFS_C4 = 3'h4;
  localparam logic [2:0]  PFS_C5 = 3'h5;
  localparam logic [2:0]  PFS_C6 = 3'h6;

  // per-pin routed function, one-hot of n+1
  typedef logic [7:0] pfs_func_t;
  // a pin out of reset shows its first function
  localparam pfs_func_t PFS_FUNC_FIRST = 8'h01;

endpackage : pfs_pkg

// File: verilog/pfs_field_dec.sv
`timescale 1ns/10ps
module pfs_field_dec
  import pfs_pkg::*;
#(
  parameter int W = 3
)(
  input  wire logic [W-1:0] code,
  input  wire logic [7:0]   legal_mask,
  output pfs_func_t         func
);

  // value n drives function n+1; illegal codes drive nothing
  always_comb
  begin
    func = '0;
    if (legal_mask[code])
    begin
      func[code] = 1'b1;
    end
  end

endmodule : pfs_field_dec

// File: verilog/pfs_pin_select.sv
`timescale 1ns/10ps
// Behaviour
// - select register is 32-bit read/write, resets to zero, all pins function one
// - field value n routes function n+1 to its pin
// - bits 1:0 choose A7, serial-B0 RTS, serial-A4 alt transmit
// - bits 3:2..13:12 choose address, clocked-serial1 or serial-A; code 3 routes nothing
// - bits 15:14,17:16 choose clocked-serial2, alt fast-serial, DMA1 request/acknowledge
// - bits 20:18 choose CS2 clock, fast-serial clock, CAN clock C, timer output
// - bits 23:21,26:24 choose CS2 sync/ss1, serial4 group E, CAN1 group B
// - bits 29:27 choose CS2 ss2, pwm output 4, pulse timer output 2
// - bits 31:30 choose address line 20 or special clock output
// - clocked-serial2 group select puts port on address lines or Ethernet pins
// - ADC interface group select routes to Ethernet or audio-serial pins
// - serial-A0 group select picks one of four pin pairs
// - serial-A4/A5 group code 1 uses address lines 6,7 or 12,13
// - fast-serial0 group select uses dedicated pins or address lines 14-16
// - CAN channel group selects are 2 bits; channel 1 code 1 uses A17/A18
// - timer clock group select picks data line 7 or data line 13 sources
module pfs_pin_select
  import pfs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [13:0] pin_addr_in,
  output logic [7:0]       pin_func_a7,
  output logic [7:0]       pin_func_a8,
  output logic [7:0]       pin_func_a9,
  output logic [7:0]       pin_func_a10,
  output logic [7:0]       pin_func_a11,
  output logic [7:0]       pin_func_a12,
  output logic [7:0]       pin_func_a13,
  output logic [7:0]       pin_func_a14,
  output logic [7:0]       pin_func_a15,
  output logic [7:0]       pin_func_a16,
  output logic [7:0]       pin_func_a17,
  output logic [7:0]       pin_func_a18,
  output logic [7:0]       pin_func_a19,
  output logic [7:0]       pin_func_a20,
  output logic [5:0]       clocked_serial2_in,
  output logic [5:0]       clocked_serial2_pins_eth,
  output logic             adc_if_on_audio,
  output logic [1:0]       serial_a0_rx_in_group,
  output logic             serial_a4_rx_in,
  output logic             serial_a5_rx_in,
  output logic             fast_serial0_rx_in,
  output logic             fast_serial0_clk_in,
  output logic             can_ch1_rx_in,
  output logic             dma1_request_in,
  output logic             timer_ext_clock1_alt,
  output logic             serial4_receive_group_e
);

  // ****************************************
  // bus slave
  // ****************************************
  logic [31:0]            pin_function_select_2;
  logic [PFS_G_WIDTH-1:0] group_sel;
  logic                   unlocked;
  logic                   lost_write;
  logic                   dp_write;
  logic                   dp_read;
  logic [7:0]             dp_addr;
  logic                   take;
  logic                   wr_select;
  logic                   wr_group;
  logic                   wr_mask;
  logic [31:0]            mask_value;

  assign take      = hsel && hready && (htrans == PFS_HTRANS_NONSEQ);
  assign wr_mask   = dp_write && (dp_addr == PFS_ADDR_MASK);
  assign wr_select = dp_write && (dp_addr == PFS_ADDR_SELECT);
  assign wr_group  = dp_write && (dp_addr == PFS_ADDR_GROUP);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else
    begin
      dp_write <= take && hwrite;
      dp_read  <= take && !hwrite;
      dp_addr  <= take ? haddr : dp_addr;
    end
  end

  // zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************
  // unlock: armed by the mask write, spent by the very next write
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      unlocked   <= 1'b0;
      mask_value <= 32'h0000_0000;
    end
    else if (dp_write)
    begin
      unlocked   <= wr_mask;
      mask_value <= wr_mask ? hwdata : mask_value;
    end
  end

  // any intervening write cancels the unlock, so writes cannot chain
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_function_select_2 <= PFS_SELECT_RESET;
    end
    else if (wr_select && unlocked && (mask_value == ~hwdata))
    begin
      pin_function_select_2 <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      group_sel <= PFS_GROUP_RESET[PFS_G_WIDTH-1:0];
    end
    else if (wr_group && unlocked && (mask_value == ~hwdata))
    begin
      group_sel <= hwdata[PFS_G_WIDTH-1:0];
    end
  end

  // sticky record of a locked select or group write, cleared by reading status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lost_write <= 1'b0;
    end
    else if ((wr_select || wr_group) && !(unlocked && (mask_value == ~hwdata)))
    begin
      lost_write <= 1'b1;
    end
    else if (dp_read && (dp_addr == PFS_ADDR_STATUS))
    begin
      lost_write <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (take && !hwrite)
    begin
      case (haddr)
        PFS_ADDR_SELECT: hrdata <= pin_function_select_2;
        PFS_ADDR_GROUP:  hrdata <= {{(32-PFS_G_WIDTH){1'b0}}, group_sel};
        PFS_ADDR_STATUS: hrdata <= {30'h0000_0000, lost_write, unlocked};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  localparam logic [7:0] LEGAL_A7  = 8'h07;
  localparam logic [7:0] LEGAL_A8  = 8'h07;
  localparam logic [7:0] LEGAL_A14 = 8'h0F;
  localparam logic [7:0] LEGAL_A16 = 8'h67;
  localparam logic [7:0] LEGAL_A17 = 8'h0F;
  localparam logic [7:0] LEGAL_A19 = 8'h0F;
  localparam logic [7:0] LEGAL_A20 = 8'h03;
  // reserved codes fall outside the legal masks and drive nothing
  localparam logic [7:0] RES_FREE  = 8'h0F;

  pfs_func_t f [14];

  pfs_field_dec #(.W(2)) u_a7 (
    .code(pin_function_select_2[PFS_F_A7_LSB +: 2]), .legal_mask(LEGAL_A7), .func(f[0]));

  genvar gi;
  generate
    for (gi = 0; gi < PFS_N_2BIT_A8; gi++)
    begin : g_a8
      pfs_field_dec #(.W(2)) u_dec (
        .code(pin_function_select_2[PFS_F_A8_LSB + 2*gi +: 2]),
        .legal_mask(LEGAL_A8),
        .func(f[gi+1]));
    end
  endgenerate

  pfs_field_dec #(.W(2)) u_a14 (
    .code(pin_function_select_2[PFS_F_A14_LSB +: 2]), .legal_mask(LEGAL_A14), .func(f[7]));
  pfs_field_dec #(.W(2)) u_a15 (
    .code(pin_function_select_2[PFS_F_A15_LSB +: 2]), .legal_mask(LEGAL_A14), .func(f[8]));
  pfs_field_dec #(.W(3)) u_a16 (
    .code(pin_function_select_2[PFS_F_A16_LSB +: 3]), .legal_mask(LEGAL_A16), .func(f[9]));
  pfs_field_dec #(.W(3)) u_a17 (
    .code(pin_function_select_2[PFS_F_A17_LSB +: 3]), .legal_mask(LEGAL_A17 & RES_FREE),
    .func(f[10]));
  pfs_field_dec #(.W(3)) u_a18 (
    .code(pin_function_select_2[PFS_F_A18_LSB +: 3]), .legal_mask(LEGAL_A17 & RES_FREE),
    .func(f[11]));
  pfs_field_dec #(.W(3)) u_a19 (
    .code(pin_function_select_2[PFS_F_A19_LSB +: 3]), .legal_mask(LEGAL_A19 & RES_FREE),
    .func(f[12]));
  pfs_field_dec #(.W(2)) u_a20 (
    .code(pin_function_select_2[PFS_F_A20_LSB +: 2]), .legal_mask(LEGAL_A20), .func(f[13]));

  // ****************************************
  // input routing from pin groups
  // ****************************************
  logic [13:0] pin_q1;
  logic [13:0] pin_q2;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_q1 <= 14'h0000;
      pin_q2 <= 14'h0000;
    end
    else
    begin
      pin_q1 <= pin_addr_in;
      pin_q2 <= pin_q1;
    end
  end

  // pin_q2 index k is address line k+7
  function automatic logic routed(input pfs_func_t fn, input logic [2:0] code,
                                  input logic grp_ok, input logic pin);
    routed = fn[code] && grp_ok && pin;
  endfunction : routed

  logic cs2_addr;
  assign cs2_addr = !group_sel[PFS_G_CS2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {pin_func_a7, pin_func_a8, pin_func_a9, pin_func_a10, pin_func_a11} <=
        {5{PFS_FUNC_FIRST}};
      {pin_func_a12, pin_func_a13, pin_func_a14, pin_func_a15} <= {4{PFS_FUNC_FIRST}};
      {pin_func_a16, pin_func_a17, pin_func_a18, pin_func_a19, pin_func_a20} <=
        {5{PFS_FUNC_FIRST}};
      clocked_serial2_in       <= 6'h00;
      clocked_serial2_pins_eth <= 6'h00;
      adc_if_on_audio          <= 1'b0;
      serial_a0_rx_in_group    <= 2'h0;
      serial_a4_rx_in          <= 1'b0;
      serial_a5_rx_in          <= 1'b0;
      fast_serial0_rx_in       <= 1'b0;
      fast_serial0_clk_in      <= 1'b0;
      can_ch1_rx_in            <= 1'b0;
      dma1_request_in          <= 1'b0;
      timer_ext_clock1_alt     <= 1'b0;
      serial4_receive_group_e  <= 1'b0;
    end
    else
    begin
      {pin_func_a7, pin_func_a8, pin_func_a9, pin_func_a10, pin_func_a11} <=
        {f[0], f[1], f[2], f[3], f[4]};
      {pin_func_a12, pin_func_a13, pin_func_a14, pin_func_a15} <= {f[5], f[6], f[7], f[8]};
      {pin_func_a16, pin_func_a17, pin_func_a18, pin_func_a19, pin_func_a20} <=
        {f[9], f[10], f[11], f[12], f[13]};
      clocked_serial2_in <= {routed(f[12], PFS_C1, cs2_addr, pin_q2[12]),
                             routed(f[11], PFS_C1, cs2_addr, pin_q2[11]),
                             routed(f[10], PFS_C1, cs2_addr, pin_q2[10]),
                             routed(f[9],  PFS_C1, cs2_addr, pin_q2[9]),
                             routed(f[8],  PFS_C1, cs2_addr, pin_q2[8]),
                             routed(f[7],  PFS_C1, cs2_addr, pin_q2[7])};
      clocked_serial2_pins_eth <= {6{group_sel[PFS_G_CS2]}};
      adc_if_on_audio <= group_sel[PFS_G_ADC];
      serial_a0_rx_in_group <= group_sel[PFS_G_SA0 +: 2];
      // A8 carries serial-A0 receive only in group 1
      serial_a4_rx_in <= 1'b0; // A6 lies outside this register; A7 is transmit only
      serial_a5_rx_in <= routed(f[5], PFS_C2,
        group_sel[PFS_G_SA5 +: 2] == PFS_GRP_ALT1, pin_q2[5]);
      fast_serial0_rx_in <= routed(f[7], PFS_C2, group_sel[PFS_G_FS0], pin_q2[7]);
      fast_serial0_clk_in <= routed(f[9], PFS_C2, group_sel[PFS_G_FS0], pin_q2[9]);
      can_ch1_rx_in <= routed(f[10], PFS_C3,
        group_sel[PFS_G_CAN1 +: 2] == PFS_GRP_ALT1, pin_q2[10]);
      dma1_request_in <= routed(f[7], PFS_C3, 1'b1, pin_q2[7]);
      timer_ext_clock1_alt <= group_sel[PFS_G_TMU];
      serial4_receive_group_e <= routed(f[10], PFS_C2, 1'b1, pin_q2[10]);
    end
  end

endmodule : pfs_pin_select

// File: tb/pfs_pin_select_sva.sv
`timescale 1ns/10ps
module pfs_pin_select_sva
  import pfs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  pin_func_a7,
  input wire logic [7:0]  pin_func_a16,
  input wire logic [7:0]  pin_func_a17,
  input wire logic [7:0]  pin_func_a19,
  input wire logic [7:0]  pin_func_a20,
  input wire logic [5:0]  clocked_serial2_in,
  input wire logic [5:0]  clocked_serial2_pins_eth
);
  // ****************************************
  // bus and pin-field checks
  // ****************************************
  logic rd_taken;
  assign rd_taken = hsel && hready && (htrans == PFS_HTRANS_NONSEQ) && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_always_a: assert property (hreadyout == 1'b1) else $error("slave stalled");
  resp_okay_a: assert property (hresp == 1'b0) else $error("error response seen");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_taken))
    else $error("read data moved without a read");
  a7_field_a: assert property ($onehot0(pin_func_a7) && pin_func_a7[7:3] == 5'h00)
    else $error("a7 routes an unknown function");
  a16_field_a: assert property (pin_func_a16[4:3] == 2'h0 && !pin_func_a16[7])
    else $error("a16 reserved code routed");
  a17_field_a: assert property (pin_func_a17[7:4] == 4'h0)
    else $error("a17 reserved code routed");
  a19_field_a: assert property ($onehot0(pin_func_a19) && pin_func_a19[7:4] == 4'h0)
    else $error("a19 reserved code routed");
  a20_field_a: assert property (pin_func_a20[7:2] == 6'h00)
    else $error("a20 reserved code routed");
  // group select gates the routed input directly, in the same cycle as clocked_serial2_pins_eth; the check still waits four cycles
  cs2_blocked_a: assert property ((clocked_serial2_pins_eth != 6'h00) [*4] |->
    clocked_serial2_in == 6'h00) else $error("port input fed from unselected group");
endmodule : pfs_pin_select_sva

bind pfs_pin_select pfs_pin_select_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pin_func_a7(pin_func_a7), .pin_func_a16(pin_func_a16),
  .pin_func_a17(pin_func_a17), .pin_func_a19(pin_func_a19), .pin_func_a20(pin_func_a20),
  .clocked_serial2_in(clocked_serial2_in), .clocked_serial2_pins_eth(clocked_serial2_pins_eth));

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import pfs_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd, sel_d, g;
  logic [13:0] pin_addr_in = 14'h0000;
  logic        bus_ready, hresp, adc_aud, sa4_rx, sa5_rx, fs0_rx, fs0_clk, can1_rx, dma1_rq;
  logic        tmu_alt, s4e;
  logic [5:0]  cs2_in, cs2_eth;
  logic [1:0]  sa0_grp;
  logic [7:0]  f [14];
  int          n_errors = 0, checked = 0;
  int          lsb [14] = '{0, 2, 4, 6, 8, 10, 12, 14, 16, 18, 21, 24, 27, 30};
  int          maxc [14] = '{2, 2, 2, 2, 2, 2, 2, 3, 3, 6, 4, 4, 4, 2};
  logic [7:0]  legal [14] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h0F, 8'h0F,
                              8'h67, 8'h0F, 8'h0F, 8'h0F, 8'h03};
  logic [31:0] rs [4] = '{32'h0925_4000, 32'h0925_4000, 32'h0040_C800, 32'h0068_8000};
  logic [31:0] rg [4] = '{32'h0, 32'h1, 32'h40, 32'h900};

  always #12.5 hclk = ~hclk;

  pfs_pin_select u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(bus_ready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(bus_ready), .hresp(hresp), .pin_addr_in(pin_addr_in),
    .pin_func_a7(f[0]), .pin_func_a8(f[1]), .pin_func_a9(f[2]), .pin_func_a10(f[3]),
    .pin_func_a11(f[4]), .pin_func_a12(f[5]), .pin_func_a13(f[6]), .pin_func_a14(f[7]),
    .pin_func_a15(f[8]), .pin_func_a16(f[9]), .pin_func_a17(f[10]), .pin_func_a18(f[11]),
    .pin_func_a19(f[12]), .pin_func_a20(f[13]), .clocked_serial2_in(cs2_in),
    .clocked_serial2_pins_eth(cs2_eth), .adc_if_on_audio(adc_aud),
    .serial_a0_rx_in_group(sa0_grp), .serial_a4_rx_in(sa4_rx), .serial_a5_rx_in(sa5_rx),
    .fast_serial0_rx_in(fs0_rx), .fast_serial0_clk_in(fs0_clk), .can_ch1_rx_in(can1_rx),
    .dma1_request_in(dma1_rq), .timer_ext_clock1_alt(tmu_alt), .serial4_receive_group_e(s4e));

  // ****************************************
  // shared tasks
  // ****************************************
  task print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wait_rdy();
    for (int i = 0; i < 16; i++)
    begin
      @(posedge hclk);
      if (bus_ready === 1'b1)
        return;
    end
    n_errors++;
    print_verdict();
  endtask : wait_rdy

  // no pipelining: address phase, then data phase with htrans idle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= PFS_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task unlock_wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, PFS_ADDR_MASK, ~d);
    xfer(1'b1, a, d);
  endtask : unlock_wr

  function automatic logic [7:0] exp_func(int p, logic [31:0] s);
    logic [2:0] c;
    c = 3'((s >> lsb[p]) & ((maxc[p] > 3) ? 7 : 3));
    return legal[p][c] ? (8'h01 << c) : 8'h00;
  endfunction : exp_func

  // draws only codes that software may write: legal or reserved, never prohibited
  function automatic logic [31:0] rand_sel();
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 14; i++)
      v = v | ($urandom_range(maxc[i], 0) << lsb[i]);
    return v;
  endfunction : rand_sel

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sel_d = $urandom(87);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 14; i++)
      check(32'(f[i]), 32'h1);
    xfer(1'b0, PFS_ADDR_SELECT, 32'h0);
    check(rd, PFS_SELECT_RESET);
    xfer(1'b0, PFS_ADDR_GROUP, 32'h0);
    check(rd, PFS_GROUP_RESET);
    xfer(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    for (int k = 0; k < 12; k++)
    begin
      // first pass: top legal codes for A7-A15 and one reserved code each in A16-A20
      sel_d = (k == 0) ? 32'hA493_EAAA : rand_sel();
      unlock_wr(PFS_ADDR_SELECT, sel_d);
      repeat (2) @(posedge hclk);
      xfer(1'b0, PFS_ADDR_SELECT, 32'h0);
      check(rd, sel_d);
      for (int i = 0; i < 14; i++)
        check(32'(f[i]), 32'(exp_func(i, sel_d)));
    end
    xfer(1'b1, PFS_ADDR_SELECT, ~sel_d);
    xfer(1'b0, PFS_ADDR_SELECT, 32'h0);
    check(rd, sel_d);
    xfer(1'b0, PFS_ADDR_STATUS, 32'h0);
    check(32'(rd[1]), 32'h1);
    xfer(1'b0, PFS_ADDR_STATUS, 32'h0);
    check(32'(rd[1]), 32'h0);
    xfer(1'b1, PFS_ADDR_MASK, ~32'h0);
    xfer(1'b1, 8'h10, 32'h0);
    xfer(1'b1, PFS_ADDR_SELECT, 32'h0);
    xfer(1'b0, PFS_ADDR_SELECT, 32'h0);
    check(rd, sel_d);
    unlock_wr(PFS_ADDR_SELECT, 32'h0);
    xfer(1'b1, PFS_ADDR_SELECT, sel_d);
    xfer(1'b0, PFS_ADDR_SELECT, 32'h0);
    check(rd, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      g = (k == 0) ? 32'h3FFF : ($urandom & 32'h3FFF);
      unlock_wr(PFS_ADDR_GROUP, g);
      repeat (2) @(posedge hclk);
      check(32'(cs2_eth), 32'({6{g[PFS_G_CS2]}}));
      check(32'(adc_aud), 32'(g[PFS_G_ADC]));
      check(32'(sa0_grp), 32'(g[PFS_G_SA0 +: 2]));
      check(32'(tmu_alt), 32'(g[PFS_G_TMU]));
    end
    for (int k = 0; k < 4; k++)
    begin
      unlock_wr(PFS_ADDR_SELECT, rs[k]);
      unlock_wr(PFS_ADDR_GROUP, rg[k]);
      repeat (4)
      begin
        pin_addr_in <= 14'($urandom);
        repeat (5) @(posedge hclk);
        if (k == 0)
          check(32'(cs2_in), 32'(pin_addr_in[12:7]));
        if (k == 1)
          check(32'(cs2_in), 32'h0);
        if (k == 2)
        begin
          check(32'(dma1_rq), 32'(pin_addr_in[7]));
          check(32'(s4e), 32'(pin_addr_in[10]));
          check(32'(sa5_rx), 32'(pin_addr_in[5]));
          check(32'(sa4_rx), 32'h0);
        end
        if (k == 3)
        begin
          check(32'(fs0_rx), 32'(pin_addr_in[7]));
          check(32'(fs0_clk), 32'(pin_addr_in[9]));
          check(32'(can1_rx), 32'(pin_addr_in[10]));
        end
      end
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(32'(f[7]), 32'h1);
    xfer(1'b0, PFS_ADDR_SELECT, 32'h0);
    check(rd, PFS_SELECT_RESET);
    print_verdict();
  end
endmodule : tb_top
